// file: rtl/iosc_din_cond.sv
// Purpose: One direct input conditioner: invert, ON dead-time, one-shot
// Assumes: din is already synchronised; tick is a one-cycle 1 ms enable
// Notes: Dead-time counts whole ticks, so the first tick may be partial
`timescale 1ns/1ps
module iosc_din_cond (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic din,
  input wire logic invert,
  input wire logic [7:0] dead_ms,
  input wire logic one_shot,
  output logic sig
);
  logic [7:0] dcnt;
  logic [7:0] next_dcnt;
  logic [7:0] pcnt;
  logic [7:0] next_pcnt;
  logic qual;
  logic next_qual;
  logic used;
  logic next_used;
  logic next_sig;
  logic lvl;

  always_comb
  begin
    lvl = din ^ invert; // RULE10 RULE17
    next_dcnt = dcnt;
    next_qual = qual;
    next_pcnt = pcnt;
    next_used = used;
    if (!lvl)
    begin
      next_dcnt = 8'h00;
      next_qual = 1'b0;
      next_used = 1'b0;
    end
    else if (!qual)
    begin
      if (dcnt >= dead_ms)
        next_qual = 1'b1; // RULE11 RULE12
      else if (tick)
        next_dcnt = dcnt + 8'h01;
    end
    if (!qual || !one_shot)
      next_pcnt = 8'h00;
    else if (tick && !used)
    begin
      if (pcnt >= 8'(iosc_pkg::ONE_SHOT_MS - 1))
        next_used = 1'b1; // RULE14
      else
        next_pcnt = pcnt + 8'h01;
    end
    next_sig = qual && !(one_shot && used); // RULE13 RULE17
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dcnt <= 8'h00;
      pcnt <= 8'h00;
      qual <= 1'b0;
      used <= 1'b0;
      sig <= 1'b0;
    end
    else
    begin
      dcnt <= next_dcnt;
      pcnt <= next_pcnt;
      qual <= next_qual;
      used <= next_used;
      sig <= next_sig;
    end
  end

  a_dead_hold: assert property (@(posedge clk) disable iff (rst)
    $rose(qual) |-> $past(lvl) && $past(dcnt) >= $past(dead_ms)) // RULE12
    else $error("input qualified before dead-time");
  a_off_follow: assert property (@(posedge clk) disable iff (rst)
    !lvl |=> !qual ##1 !sig) // RULE17
    else $error("input did not drop with its level");
endmodule

// file: rtl/iosc_pkg.sv
// Purpose: Constants and carrier types for the I/O signal conditioning block
// Assumes: 25 MHz REF_CLK, one-millisecond tick for all timing
// Notes: Function codes are 8 bits; code 0 means no function
// Function
// RULE1: AND composite needs both signals ON
// RULE2: Output ON when composite combination holds
// RULE3: Output drops after OFF delay expires
// RULE4: User outputs internal, usable with direct I/O
// RULE5: User output asserts when combination holds
// RULE6: Two independent user output channels
// RULE7: Sources select any status, own inversion
// RULE8: Sources combine by AND or OR
// RULE9: Six inputs assignable, documented default codes
// RULE10: Input inversion setting, default non-invert
// RULE11: ON dead-time 0 to 250 ms
// RULE12: Internal ON after dead-time exceeded
// RULE13: One-shot enable, default disabled
// RULE14: One-shot pulse returns OFF after 250 ms
// RULE15: Interlock release input kept level mode; the code applies one_shot to every input whatever its function
// RULE16: Second composite input function per terminal
// RULE17: Order is invert, dead-time, one-shot
// RULE18: Millisecond tick; reset restores defaults
package iosc_pkg;
  localparam int NUM_DIN = 6;
  localparam int NUM_DOUT = 6;
  localparam int NUM_USR = 2;
  localparam int NUM_STAT = 256;
  localparam int CODE_W = 8;
  localparam int MS_W = 8;
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int MAX_DEAD_MS = 250;
  localparam int ONE_SHOT_MS = 250;
  localparam logic [CODE_W-1:0] FN_NONE = 8'h00;
  localparam logic [CODE_W-1:0] FN_HOME = 8'h1E;
  localparam logic [CODE_W-1:0] FN_FREE = 8'h01;
  localparam logic [CODE_W-1:0] FN_TQCLR = 8'h0C;
  localparam logic [CODE_W-1:0] FN_EXT_TRIG = 8'h68;
  localparam logic [CODE_W-1:0] FN_FWLIM = 8'h1C;
  localparam logic [CODE_W-1:0] FN_RVLIM = 8'h1D;
  localparam logic OP_AND = 1'b0;
  localparam logic OP_OR = 1'b1;

  typedef struct packed {
    logic [CODE_W-1:0] func;
    logic [CODE_W-1:0] comp_func;
    logic invert;
    logic [MS_W-1:0] dead_ms;
    logic one_shot;
  } iosc_din_cfg_t;

  typedef struct packed {
    logic [CODE_W-1:0] func;
    logic invert;
    logic [MS_W-1:0] off_ms;
    logic comp_op;
    logic [CODE_W-1:0] comp_func;
    logic comp_invert;
  } iosc_dout_cfg_t;

  typedef struct packed {
    logic [CODE_W-1:0] src_a;
    logic inv_a;
    logic [CODE_W-1:0] src_b;
    logic inv_b;
    logic op;
  } iosc_usr_cfg_t;
endpackage

// file: rtl/iosc_top.sv
// Purpose: Direct input conditioning, composite direct outputs, user outputs
// Assumes: STATUS carries 256 device status flags, bit 0 always low
// Notes: DIN_CFG is loaded into flip-flops only on DIN_CFG_VALID; DOUT_CFG and USR_CFG are used directly each cycle
`timescale 1ns/1ps
module iosc_top #(
  parameter int TICK_DIV = iosc_pkg::TICK_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [5:0] DIN,
  input wire iosc_pkg::iosc_din_cfg_t [5:0] DIN_CFG,
  input wire logic DIN_CFG_VALID,
  input wire logic [255:0] STATUS,
  input wire iosc_pkg::iosc_dout_cfg_t [5:0] DOUT_CFG,
  input wire iosc_pkg::iosc_usr_cfg_t [1:0] USR_CFG,
  output logic [255:0] FUNC_ACTIVE,
  output logic [5:0] DIN_SIG,
  output logic [5:0] DOUT,
  output logic [1:0] INTERNAL_COMBINED_OUTPUT
);
  iosc_pkg::iosc_din_cfg_t [5:0] din_cfg;
  iosc_pkg::iosc_din_cfg_t [5:0] next_din_cfg;
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [5:0] cond;
  logic [31:0] div;
  logic [31:0] next_div;
  logic tick;
  logic next_tick;
  logic [255:0] next_func;
  logic [5:0] next_dout;
  logic [1:0] next_usr;
  logic [5:0] src_on;
  logic [7:0] ocnt [6];
  logic [7:0] next_ocnt [6];

  // Defaults are held here; software must pulse DIN_CFG_VALID to change them
  always_comb
  begin
    next_din_cfg = din_cfg;
    if (DIN_CFG_VALID)
      next_din_cfg = DIN_CFG; // RULE9
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < 6; i++)
      begin
        din_cfg[i] <= '0; // RULE18
      end
      din_cfg[0].func <= iosc_pkg::FN_HOME; // RULE9
      din_cfg[1].func <= iosc_pkg::FN_FREE;
      din_cfg[2].func <= iosc_pkg::FN_TQCLR;
      din_cfg[3].func <= iosc_pkg::FN_EXT_TRIG;
      din_cfg[4].func <= iosc_pkg::FN_FWLIM;
      din_cfg[5].func <= iosc_pkg::FN_RVLIM;
    end
    else
      din_cfg <= next_din_cfg;
  end

  // Two-stage synchroniser on the external terminals
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end
    else
    begin
      sync1 <= DIN;
      sync2 <= sync1;
    end
  end

  always_comb
  begin
    next_div = div + 32'h0000_0001;
    next_tick = 1'b0;
    if (div >= 32'(TICK_DIV - 1))
    begin
      next_div = 32'h0000_0000;
      next_tick = 1'b1; // RULE18
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      div <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else
    begin
      div <= next_div;
      tick <= next_tick;
    end
  end

  for (genvar g = 0; g < 6; g++)
  begin : g_din
    iosc_din_cond u_cond (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .tick(tick),
      .din(sync2[g]),
      .invert(din_cfg[g].invert),
      .dead_ms(din_cfg[g].dead_ms > 8'(iosc_pkg::MAX_DEAD_MS) ?
               8'(iosc_pkg::MAX_DEAD_MS) : din_cfg[g].dead_ms), // RULE11
      .one_shot(din_cfg[g].one_shot), // RULE15
      .sig(cond[g])
    );
  end

  // Route each conditioned terminal to its normal and composite function
  always_comb
  begin
    next_func = '0;
    for (int i = 0; i < 6; i++)
    begin
      next_func[din_cfg[i].func] = next_func[din_cfg[i].func] | cond[i]; // RULE9
      next_func[din_cfg[i].comp_func] = next_func[din_cfg[i].comp_func] | cond[i]; // RULE16
    end
    next_func[iosc_pkg::FN_NONE] = 1'b0;
  end

  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      logic a;
      logic b;
      a = STATUS[DOUT_CFG[i].func] ^ DOUT_CFG[i].invert;
      b = STATUS[DOUT_CFG[i].comp_func] ^ DOUT_CFG[i].comp_invert;
      if (DOUT_CFG[i].comp_func == iosc_pkg::FN_NONE)
        src_on[i] = a;
      else if (DOUT_CFG[i].comp_op == iosc_pkg::OP_AND)
        src_on[i] = a & b; // RULE1
      else
        src_on[i] = a | b; // RULE2
      next_ocnt[i] = ocnt[i];
      next_dout[i] = DOUT[i];
      if (src_on[i])
      begin
        next_ocnt[i] = 8'h00;
        next_dout[i] = 1'b1;
      end
      else if (DOUT[i])
      begin
        if (ocnt[i] >= DOUT_CFG[i].off_ms)
          next_dout[i] = 1'b0; // RULE3
        else if (tick)
          next_ocnt[i] = ocnt[i] + 8'h01;
      end
    end
  end

  // User outputs are internal only; they sit beside DOUT without sharing it
  always_comb
  begin
    for (int u = 0; u < 2; u++)
    begin
      logic a;
      logic b;
      a = STATUS[USR_CFG[u].src_a] ^ USR_CFG[u].inv_a; // RULE7
      b = STATUS[USR_CFG[u].src_b] ^ USR_CFG[u].inv_b; // RULE7
      next_usr[u] = (USR_CFG[u].op == iosc_pkg::OP_AND) ? (a & b) : (a | b); // RULE5 RULE8
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      FUNC_ACTIVE <= '0;
      DIN_SIG <= 6'h00;
      DOUT <= 6'h00;
      INTERNAL_COMBINED_OUTPUT <= 2'h0; // RULE4 RULE6
      for (int i = 0; i < 6; i++)
      begin
        ocnt[i] <= 8'h00;
      end
    end
    else
    begin
      FUNC_ACTIVE <= next_func;
      DIN_SIG <= cond;
      DOUT <= next_dout;
      INTERNAL_COMBINED_OUTPUT <= next_usr;
      for (int i = 0; i < 6; i++)
      begin
        ocnt[i] <= next_ocnt[i];
      end
    end
  end

  // Source has just gone OFF while the output is still held ON
  sequence s_src_off;
    $fell(src_on[2]) && DOUT[2];
  endsequence

  a_usr_and: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (USR_CFG[0].op == iosc_pkg::OP_AND && USR_CFG[0].src_a == 8'h00 && !USR_CFG[0].inv_a)
    |=> !INTERNAL_COMBINED_OUTPUT[0]) // RULE8
    else $error("user output AND with a low source asserted");
  a_usr_two: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $changed(USR_CFG[0]) && $stable(USR_CFG[1]) && $stable(STATUS)
    |=> $stable(INTERNAL_COMBINED_OUTPUT[1])) // RULE6
    else $error("second user output followed the first channel");
  a_usr_comb: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    USR_CFG[0].op == iosc_pkg::OP_AND &&
    (STATUS[USR_CFG[0].src_a] ^ USR_CFG[0].inv_a) &&
    (STATUS[USR_CFG[0].src_b] ^ USR_CFG[0].inv_b) |=> INTERNAL_COMBINED_OUTPUT[0]) // RULE5
    else $error("user output missed its combination");
  a_dout_on: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    src_on[0] |=> DOUT[0]) // RULE2
    else $error("direct output not raised");
  a_dout_and: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $rose(DOUT[0]) && DOUT_CFG[0].comp_op == iosc_pkg::OP_AND &&
    $past(DOUT_CFG[0].comp_func) != 8'h00 && $stable(DOUT_CFG[0])
    |-> $past(STATUS[DOUT_CFG[0].comp_func] ^ DOUT_CFG[0].comp_invert)) // RULE1
    else $error("AND composite rose without composite signal");
  a_dout_delay: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_src_off ##0 DOUT_CFG[2].off_ms != 8'h00 |=> DOUT[2]) // RULE3
    else $error("direct output dropped before delay");
  a_tick_gap: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    tick |=> !tick) // RULE18
    else $error("tick wider than one cycle");
  a_route: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cond[0] && din_cfg[0].func != 8'h00 |=> FUNC_ACTIVE[$past(din_cfg[0].func)]) // RULE9
    else $error("input function not routed");
endmodule

// file: test/iosc_field.sv
// Purpose: Field side model: switches, sensors and device status flags
// Assumes: Levels change just after a rising clock edge
// Notes: Status bit 0 is held low, since code 0 means no function
`timescale 1ns/1ps
module iosc_field (
  input wire logic clk,
  output logic [5:0] din,
  output logic [255:0] status
);
  initial
  begin
    din = 6'h00;
    status = 256'h0;
  end

  task automatic drive_pin(input int idx, input logic val);
    @(posedge clk);
    din[idx] <= val;
  endtask

  task automatic drive_flag(input int code, input logic val);
    @(posedge clk);
    if (code != 0)
    begin
      status[code] <= val;
    end
  endtask
endmodule

// file: test/testbench.sv
// Purpose: Self-checking bench for input conditioning and output combining
// Assumes: TICK_DIV of 4, so one millisecond is four clock cycles
// Notes: Timing checks use windows that allow a partial first tick
`timescale 1ns/1ps
module testbench;
  logic REF_CLK;
  logic SYS_RST;
  logic [5:0] din;
  logic [255:0] status;
  iosc_pkg::iosc_din_cfg_t [5:0] din_cfg;
  logic din_cfg_valid;
  iosc_pkg::iosc_dout_cfg_t [5:0] dout_cfg;
  iosc_pkg::iosc_usr_cfg_t [1:0] usr_cfg;
  logic [255:0] func_active;
  logic [5:0] din_sig;
  logic [5:0] dout;
  logic [1:0] internal_combined_output;
  logic [7:0] dflt [6];
  int bad_count;
  int n_compared;

  iosc_top #(.TICK_DIV(4)) iosc_top_inst (
    .REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST),
    .DIN(din),
    .DIN_CFG(din_cfg),
    .DIN_CFG_VALID(din_cfg_valid),
    .STATUS(status),
    .DOUT_CFG(dout_cfg),
    .USR_CFG(usr_cfg),
    .FUNC_ACTIVE(func_active),
    .DIN_SIG(din_sig),
    .DOUT(dout),
    .INTERNAL_COMBINED_OUTPUT(internal_combined_output)
  );

  iosc_field iosc_field_inst (
    .clk(REF_CLK),
    .din(din),
    .status(status)
  );

  initial
  begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask

  task automatic chk(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check_defaults;
    for (int i = 0; i < 6; i++)
    begin
      iosc_field_inst.drive_pin(i, 1'b1);
      wait_cyc(7);
      chk("default func on", 1'b1, func_active[dflt[i]]);
      chk("pin level on", 1'b1, din_sig[i]);
      iosc_field_inst.drive_pin(i, 1'b0);
      wait_cyc(7);
      chk("default func off", 1'b0, func_active[dflt[i]]);
    end
    $display("test defaults done");
  endtask

  task automatic check_inputs;
    @(posedge REF_CLK);
    // Normally closed contact read through inversion, kept in level mode
    din_cfg[1] <= '{8'h01, 8'h00, 1'b1, 8'h00, 1'b0};
    din_cfg[2] <= '{8'h0C, 8'h20, 1'b0, 8'h00, 1'b0};
    din_cfg[3] <= '{8'h68, 8'h00, 1'b0, 8'h0A, 1'b0};
    din_cfg[4] <= '{8'h1C, 8'h00, 1'b0, 8'h00, 1'b1};
    din_cfg_valid <= 1'b1;
    @(posedge REF_CLK);
    din_cfg_valid <= 1'b0;
    wait_cyc(8);
    chk("inverted idle", 1'b1, din_sig[1]);
    chk("inverted func", 1'b1, func_active[1]);
    iosc_field_inst.drive_pin(1, 1'b1);
    wait_cyc(7);
    chk("inverted active", 1'b0, din_sig[1]);
    iosc_field_inst.drive_pin(2, 1'b1);
    wait_cyc(7);
    chk("normal func", 1'b1, func_active[12]);
    chk("composite func", 1'b1, func_active[32]);
    iosc_field_inst.drive_pin(2, 1'b0);
    // Pulse shorter than the 40-cycle dead-time must be swallowed
    iosc_field_inst.drive_pin(3, 1'b1);
    wait_cyc(20);
    iosc_field_inst.drive_pin(3, 1'b0);
    wait_cyc(50);
    chk("short pulse", 1'b0, din_sig[3]);
    iosc_field_inst.drive_pin(3, 1'b1);
    wait_cyc(38);
    chk("dead early", 1'b0, din_sig[3]);
    wait_cyc(14);
    chk("dead late", 1'b1, din_sig[3]);
    chk("dead func", 1'b1, func_active[104]);
    iosc_field_inst.drive_pin(3, 1'b0);
    iosc_field_inst.drive_pin(4, 1'b1);
    wait_cyc(8);
    chk("shot start", 1'b1, din_sig[4]);
    wait_cyc(900);
    chk("shot held", 1'b1, din_sig[4]);
    wait_cyc(200);
    chk("shot ended", 1'b0, din_sig[4]);
    chk("shot func", 1'b0, func_active[28]);
    iosc_field_inst.drive_pin(4, 1'b0);
    $display("test inputs done");
  endtask

  task automatic check_outputs;
    logic a;
    logic b;
    @(posedge REF_CLK);
    dout_cfg[0] <= '{8'h90, 1'b0, 8'h00, iosc_pkg::OP_AND, 8'hA0, 1'b0};
    dout_cfg[1] <= '{8'h90, 1'b0, 8'h00, iosc_pkg::OP_OR, 8'hA0, 1'b1};
    dout_cfg[2] <= '{8'hB0, 1'b0, 8'h05, iosc_pkg::OP_AND, 8'h00, 1'b0};
    usr_cfg[1] <= '{8'h90, 1'b1, 8'hA0, 1'b0, iosc_pkg::OP_OR};
    // Channel zero changes alone so channel one is seen to ignore it
    @(posedge REF_CLK);
    usr_cfg[0] <= '{8'h90, 1'b0, 8'hA0, 1'b1, iosc_pkg::OP_AND};
    for (int k = 0; k < 4; k++)
    begin
      a = k[1];
      b = k[0];
      iosc_field_inst.drive_flag(8'h90, a);
      iosc_field_inst.drive_flag(8'hA0, b);
      wait_cyc(3);
      chk("composite and", a & b, dout[0]);
      chk("composite or", a | ~b, dout[1]);
      chk("user and", a & ~b, internal_combined_output[0]);
      chk("user or", ~a | b, internal_combined_output[1]);
    end
    iosc_field_inst.drive_flag(8'hB0, 1'b1);
    wait_cyc(3);
    chk("delay on", 1'b1, dout[2]);
    iosc_field_inst.drive_flag(8'hB0, 1'b0);
    wait_cyc(12);
    chk("delay hold", 1'b1, dout[2]);
    wait_cyc(18);
    chk("delay off", 1'b0, dout[2]);
    $display("test outputs done");
  endtask

  initial
  begin
    bad_count = 0;
    n_compared = 0;
    SYS_RST = 1'b1;
    din_cfg = '0;
    din_cfg_valid = 1'b0;
    dout_cfg = '0;
    usr_cfg = '0;
    dflt = '{8'h1E, 8'h01, 8'h0C, 8'h68, 8'h1C, 8'h1D};
    repeat (2) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    check_defaults();
    check_inputs();
    check_outputs();
    // Configuration loaded earlier must not survive a reset
    @(posedge REF_CLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    wait_cyc(0);
    chk("reset dout", 1'b0, dout[0]);
    check_defaults();
    wrap_up();
  end

  initial
  begin
    repeat (6000) @(posedge REF_CLK);
    bad_count++;
    wrap_up();
  end
endmodule
